/* File: core/cos_defs.vh */
`ifndef COS_DEFS_VH
`define COS_DEFS_VH

// Controller clock
`define COS_CLK_MHZ 20

// Command codes
`define COS_CMD_ONOFF_CFG 8'h02
`define COS_CMD_VOUT_TGT 8'h21
`define COS_CMD_OUTPUT_VOLTAGE_TRIM 8'h22
`define COS_CMD_OT_WARN 8'h51
`define COS_CMD_TON_DLY 8'h60
`define COS_CMD_TURN_ON_RISE_TIME 8'h61
`define COS_CMD_TOFF_DLY 8'h64
`define COS_CMD_TURN_OFF_FALL_TIME 8'h65
`define COS_CMD_SINK_LIM 8'h66
`define COS_CMD_STATUS 8'h7e

// Field positions
`define COS_SOFT_STOP_BIT 0

// Reset values
`define COS_ONOFF_RST 8'h00
`define COS_VOUT_RST 16'h3000
`define COS_TRIM_RST 16'h0000
`define COS_OT_WARN_RST 16'h0064
`define COS_TON_DLY_RST 16'h0000
`define COS_RISE_RST 16'h2710
`define COS_TOFF_DLY_RST 16'h0000
`define COS_FALL_RST 16'h2710
`define COS_SINK_LIM_RST 16'h2710

// Timing
`define COS_RC_MIN_US 150
`define COS_RC_DEB_CYC (`COS_RC_MIN_US * `COS_CLK_MHZ)
`define COS_BOOT_MS 15
`define COS_BOOT_CYC (`COS_BOOT_MS * 1000 * `COS_CLK_MHZ)

// Sequencer states
`define COS_S_BOOT 3'd0
`define COS_S_OFF 3'd1
`define COS_S_ONDLY 3'd2
`define COS_S_RISE 3'd3
`define COS_S_REG 3'd4
`define COS_S_OFFDLY 3'd5
`define COS_S_FALL 3'd6

`endif

/* File: core/cos_sequencer.v */
`include "cos_defs.vh"

module cos_sequencer #(
    parameter [18:0] BOOT_CYCLES = `COS_BOOT_CYC,
    parameter [15:0] VIN_ON = 16'h0800,
    parameter [15:0] VIN_OFF = 16'h0700,
    parameter [15:0] VIN_OV = 16'h0f00,
    parameter [15:0] VIN_UV = 16'h0600,
    parameter [15:0] VOUT_OV = 16'h4000,
    parameter [15:0] VOUT_MAX = 16'h3800,
    parameter [15:0] VOUT_MIN = 16'h2000,
    parameter [15:0] OT_FAULT = 16'h0078,
    parameter [15:0] UT_FAULT = 16'h0010,
    parameter [15:0] UT_CLEAR = 16'h0014,
    parameter UT_SHUTDOWN = 0
) (
    // Clock and reset
    input wire CLK_SYS_IN,
    input wire RESETN_IN,
    // Command port
    input wire CMD_WR_IN,
    input wire CMD_RD_IN,
    input wire [7:0] CMD_CODE_IN,
    input wire [15:0] CMD_WDATA_IN,
    output reg [15:0] CMD_RDATA_OUT,
    output reg CMD_ACK_OUT,
    output reg CMD_ERR_OUT,
    // Monitors and control pins
    input wire REMOTE_ONOFF_PIN_IN,
    input wire [1:0] MARGIN_IN,
    input wire [15:0] VIN_MON_IN,
    input wire [15:0] VOUT_MON_IN,
    input wire [15:0] TEMP_MON_IN,
    // Power stage control and status
    output reg REG_EN_OUT,
    output reg SINK_EN_OUT,
    output reg [15:0] VREF_OUT,
    output reg [2:0] STATE_OUT,
    output reg [4:0] FAULT_OUT
);

    localparam [11:0] RC_DEB = `COS_RC_DEB_CYC;

    reg [7:0] on_off_configuration;
    reg [15:0] output_voltage_target;
    reg [15:0] output_voltage_trim;
    reg [15:0] over_temp_warning_limit;
    reg [15:0] turn_on_delay;
    reg [15:0] turn_on_rise_time;
    reg [15:0] turn_off_delay;
    reg [15:0] turn_off_fall_time;
    reg [15:0] prebias_sink_time_limit;

    reg rc_s1;
    reg rc_s2;
    reg rc_stable;
    reg [11:0] deb_cnt;
    reg vin_ok;
    reg ot;
    reg ut;
    reg vin_ov;
    reg vin_uv;
    reg vout_ov;
    reg [18:0] boot_cnt;
    reg [21:0] tmr;
    reg [21:0] dly_lat;
    reg [21:0] rise_lat;
    reg [21:0] fall_lat;
    reg [21:0] snk_lat;
    reg [21:0] snk_tmr;
    reg [21:0] dur;
    reg [22:0] acc;
    reg [15:0] span;
    reg [15:0] goal;
    reg dir_up;
    reg [15:0] status_word;
    reg [15:0] rd_data;
    reg rd_hit;

    wire [15:0] nom = output_voltage_target + output_voltage_trim;
    wire [15:0] tenth = nom / 16'd10;
    wire [16:0] up_sum = {1'b0, nom} + {1'b0, tenth};
    wire [16:0] dn_dif = {1'b0, nom} - {1'b0, tenth};
    reg [15:0] target;

    // Microseconds to clock cycles, times twenty
    function [21:0] us2cyc;
        input [15:0] us;
        begin
            us2cyc = {2'b00, us, 4'h0} + {4'h0, us, 2'b00};
        end
    endfunction

    wire [22:0] acc_sum = acc + {7'h00, span};
    wire step = (acc_sum >= {1'b0, dur});
    wire at_goal = (VREF_OUT == goal);
    wire rc_on = ~rc_stable;
    wire fault_any = ot | vin_ov | vin_uv | vout_ov | (ut & (UT_SHUTDOWN != 0));
    wire run_ok = vin_ok & rc_on & ~fault_any;
    wire soft_stop = on_off_configuration[`COS_SOFT_STOP_BIT];

    always @* begin
        target = nom;
        if (MARGIN_IN == 2'b01) begin
            if (up_sum > {1'b0, VOUT_MAX}) begin
                target = VOUT_MAX;
            end else begin
                target = up_sum[15:0];
            end
        end else if (MARGIN_IN == 2'b10) begin
            if (dn_dif[16] || dn_dif[15:0] < VOUT_MIN) begin
                target = VOUT_MIN;
            end else begin
                target = dn_dif[15:0];
            end
        end
    end

    always @* begin
        status_word = {6'h00, STATE_OUT, vin_ok, rc_on, FAULT_OUT};
        rd_hit = 1'b1;
        case (CMD_CODE_IN)
            `COS_CMD_ONOFF_CFG: rd_data = {8'h00, on_off_configuration};
            `COS_CMD_VOUT_TGT: rd_data = output_voltage_target;
            `COS_CMD_OUTPUT_VOLTAGE_TRIM: rd_data = output_voltage_trim;
            `COS_CMD_OT_WARN: rd_data = over_temp_warning_limit;
            `COS_CMD_TON_DLY: rd_data = turn_on_delay;
            `COS_CMD_TURN_ON_RISE_TIME: rd_data = turn_on_rise_time;
            `COS_CMD_TOFF_DLY: rd_data = turn_off_delay;
            `COS_CMD_TURN_OFF_FALL_TIME: rd_data = turn_off_fall_time;
            `COS_CMD_SINK_LIM: rd_data = prebias_sink_time_limit;
            `COS_CMD_STATUS: rd_data = status_word;
            default: begin
                rd_data = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Command writes and reads
    always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            on_off_configuration <= `COS_ONOFF_RST;
            output_voltage_target <= `COS_VOUT_RST;
            output_voltage_trim <= `COS_TRIM_RST;
            over_temp_warning_limit <= `COS_OT_WARN_RST;
            turn_on_delay <= `COS_TON_DLY_RST;
            turn_on_rise_time <= `COS_RISE_RST;
            turn_off_delay <= `COS_TOFF_DLY_RST;
            turn_off_fall_time <= `COS_FALL_RST;
            prebias_sink_time_limit <= `COS_SINK_LIM_RST;
            CMD_RDATA_OUT <= 16'h0000;
            CMD_ACK_OUT <= 1'b0;
            CMD_ERR_OUT <= 1'b0;
        end else begin
            CMD_ACK_OUT <= (CMD_WR_IN | CMD_RD_IN) & rd_hit;
            CMD_ERR_OUT <= (CMD_WR_IN | CMD_RD_IN) & ~rd_hit;
            if (CMD_RD_IN) begin
                CMD_RDATA_OUT <= rd_data;
            end
            if (CMD_WR_IN) begin
                case (CMD_CODE_IN)
                    `COS_CMD_ONOFF_CFG: begin
                        on_off_configuration <= CMD_WDATA_IN[7:0];
                    end
                    `COS_CMD_VOUT_TGT: output_voltage_target <= CMD_WDATA_IN;
                    `COS_CMD_OUTPUT_VOLTAGE_TRIM: output_voltage_trim <= CMD_WDATA_IN;
                    `COS_CMD_OT_WARN: over_temp_warning_limit <= CMD_WDATA_IN;
                    `COS_CMD_TON_DLY: turn_on_delay <= CMD_WDATA_IN;
                    `COS_CMD_TURN_ON_RISE_TIME: turn_on_rise_time <= CMD_WDATA_IN;
                    `COS_CMD_TOFF_DLY: turn_off_delay <= CMD_WDATA_IN;
                    `COS_CMD_TURN_OFF_FALL_TIME: turn_off_fall_time <= CMD_WDATA_IN;
                    `COS_CMD_SINK_LIM: prebias_sink_time_limit <= CMD_WDATA_IN;
                    default: ;
                endcase
            end
        end
    end

    // Remote pin conditioning and monitor faults
    always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rc_s1 <= 1'b1;
            rc_s2 <= 1'b1;
            rc_stable <= 1'b1;
            deb_cnt <= 12'h000;
            vin_ok <= 1'b0;
            ot <= 1'b0;
            ut <= 1'b0;
            vin_ov <= 1'b0;
            vin_uv <= 1'b0;
            vout_ov <= 1'b0;
            FAULT_OUT <= 5'h00;
        end else begin
            rc_s1 <= REMOTE_ONOFF_PIN_IN;
            rc_s2 <= rc_s1;
            if (rc_s2 == rc_stable) begin
                deb_cnt <= 12'h000;
            end else if (deb_cnt == RC_DEB - 12'h001) begin
                rc_stable <= rc_s2;
                deb_cnt <= 12'h000;
            end else begin
                deb_cnt <= deb_cnt + 12'h001;
            end
            if (VIN_MON_IN >= VIN_ON) begin
                vin_ok <= 1'b1;
            end else if (VIN_MON_IN < VIN_OFF) begin
                vin_ok <= 1'b0;
            end
            if (TEMP_MON_IN > OT_FAULT) begin
                ot <= 1'b1;
            end else if (TEMP_MON_IN < over_temp_warning_limit) begin
                ot <= 1'b0;
            end
            if (TEMP_MON_IN < UT_FAULT) begin
                ut <= 1'b1;
            end else if (TEMP_MON_IN >= UT_CLEAR) begin
                ut <= 1'b0;
            end
            vin_ov <= (VIN_MON_IN > VIN_OV);
            vin_uv <= (VIN_MON_IN < VIN_UV);
            vout_ov <= (VOUT_MON_IN > VOUT_OV);
            FAULT_OUT <= {vout_ov, vin_uv, vin_ov, ut, ot};
        end
    end

    // Sequencer
    always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            STATE_OUT <= `COS_S_BOOT;
            REG_EN_OUT <= 1'b0;
            SINK_EN_OUT <= 1'b0;
            VREF_OUT <= 16'h0000;
            boot_cnt <= 19'h00000;
            tmr <= 22'h000000;
            dly_lat <= 22'h000000;
            rise_lat <= 22'h000000;
            fall_lat <= 22'h000000;
            snk_lat <= 22'h000000;
            snk_tmr <= 22'h000000;
            dur <= 22'h000000;
            acc <= 23'h000000;
            span <= 16'h0000;
            goal <= 16'h0000;
            dir_up <= 1'b1;
        end else if (fault_any && STATE_OUT != `COS_S_BOOT) begin
            STATE_OUT <= `COS_S_OFF;
            REG_EN_OUT <= 1'b0;
            SINK_EN_OUT <= 1'b0;
            VREF_OUT <= 16'h0000;
        end else begin
            case (STATE_OUT)
                `COS_S_BOOT: begin
                    if (boot_cnt == BOOT_CYCLES - 19'h00001) begin
                        STATE_OUT <= `COS_S_OFF;
                    end else begin
                        boot_cnt <= boot_cnt + 19'h00001;
                    end
                end
                `COS_S_OFF: begin
                    REG_EN_OUT <= 1'b0;
                    SINK_EN_OUT <= 1'b0;
                    VREF_OUT <= 16'h0000;
                    if (run_ok) begin
                        tmr <= 22'h000000;
                        dly_lat <= us2cyc(turn_on_delay);
                        rise_lat <= us2cyc(turn_on_rise_time);
                        snk_lat <= us2cyc(prebias_sink_time_limit);
                        STATE_OUT <= `COS_S_ONDLY;
                    end
                end
                `COS_S_ONDLY: begin
                    if (!run_ok) begin
                        STATE_OUT <= `COS_S_OFF;
                    end else if (tmr >= dly_lat) begin
                        VREF_OUT <= VOUT_MON_IN;
                        goal <= target;
                        acc <= 23'h000000;
                        dur <= rise_lat;
                        snk_tmr <= 22'h000000;
                        REG_EN_OUT <= 1'b1;
                        STATE_OUT <= `COS_S_RISE;
                        if (VOUT_MON_IN > target) begin
                            dir_up <= 1'b0;
                            span <= VOUT_MON_IN - target;
                            SINK_EN_OUT <= 1'b1;
                        end else begin
                            dir_up <= 1'b1;
                            span <= target - VOUT_MON_IN;
                            SINK_EN_OUT <= 1'b0;
                        end
                    end else begin
                        tmr <= tmr + 22'h000001;
                    end
                end
                `COS_S_RISE, `COS_S_FALL: begin
                    if (STATE_OUT == `COS_S_RISE && !run_ok) begin
                        if (soft_stop) begin
                            tmr <= 22'h000000;
                            dly_lat <= us2cyc(turn_off_delay);
                            fall_lat <= us2cyc(turn_off_fall_time);
                            SINK_EN_OUT <= 1'b1;
                            STATE_OUT <= `COS_S_OFFDLY;
                        end else begin
                            REG_EN_OUT <= 1'b0;
                            SINK_EN_OUT <= 1'b0;
                            VREF_OUT <= 16'h0000;
                            STATE_OUT <= `COS_S_OFF;
                        end
                    end else if (at_goal) begin
                        if (STATE_OUT == `COS_S_RISE) begin
                            SINK_EN_OUT <= 1'b1;
                            STATE_OUT <= `COS_S_REG;
                        end else begin
                            REG_EN_OUT <= 1'b0;
                            SINK_EN_OUT <= 1'b0;
                            STATE_OUT <= `COS_S_OFF;
                        end
                    end else begin
                        if (dur == 22'h000000) begin
                            VREF_OUT <= goal;
                        end else if (step) begin
                            acc <= acc_sum - {1'b0, dur};
                            if (dir_up) begin
                                VREF_OUT <= VREF_OUT + 16'h0001;
                            end else begin
                                VREF_OUT <= VREF_OUT - 16'h0001;
                            end
                        end else begin
                            acc <= acc_sum;
                        end
                        if (STATE_OUT == `COS_S_RISE && !dir_up) begin
                            snk_tmr <= snk_tmr + 22'h000001;
                            if (snk_tmr >= snk_lat) begin
                                SINK_EN_OUT <= 1'b0;
                            end
                        end
                    end
                end
                `COS_S_REG: begin
                    // Target edits apply as a step
                    VREF_OUT <= target;
                    if (!run_ok) begin
                        if (soft_stop) begin
                            tmr <= 22'h000000;
                            dly_lat <= us2cyc(turn_off_delay);
                            fall_lat <= us2cyc(turn_off_fall_time);
                            STATE_OUT <= `COS_S_OFFDLY;
                        end else begin
                            REG_EN_OUT <= 1'b0;
                            SINK_EN_OUT <= 1'b0;
                            VREF_OUT <= 16'h0000;
                            STATE_OUT <= `COS_S_OFF;
                        end
                    end
                end
                `COS_S_OFFDLY: begin
                    if (tmr >= dly_lat) begin
                        // delay done, ramp to 0 V
                        goal <= 16'h0000;
                        span <= VREF_OUT;
                        dur <= fall_lat;
                        acc <= 23'h000000;
                        dir_up <= 1'b0;
                        STATE_OUT <= `COS_S_FALL;
                    end else begin
                        tmr <= tmr + 22'h000001;
                    end
                end
                default: STATE_OUT <= `COS_S_OFF;
            endcase
        end
    end

endmodule // cos_sequencer

/* File: testbench/cos_seq_asserts.sv */
`include "cos_defs.vh"

module cos_seq_asserts #(
    parameter [18:0] BOOT_CYCLES = 19'd100,
    parameter [15:0] VIN_OFF = 16'h0700,
    parameter [15:0] VIN_OV = 16'h0f00,
    parameter [15:0] VOUT_OV = 16'h4000,
    parameter [15:0] OT_FAULT = 16'h0078
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    // Command port
    input wire logic CMD_WR_IN,
    input wire logic CMD_RD_IN,
    input wire logic [15:0] CMD_RDATA_OUT,
    input wire logic CMD_ACK_OUT,
    input wire logic CMD_ERR_OUT,
    // Monitors and power stage
    input wire logic REMOTE_ONOFF_PIN_IN,
    input wire logic [15:0] VIN_MON_IN,
    input wire logic [15:0] VOUT_MON_IN,
    input wire logic [15:0] TEMP_MON_IN,
    input wire logic REG_EN_OUT,
    input wire logic SINK_EN_OUT,
    input wire logic [2:0] STATE_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] low_cnt;
    logic [18:0] boot_cnt;

    // Saturating, so long holds never wrap back under the limit
    always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            low_cnt <= 12'h000;
            boot_cnt <= 19'h00000;
        end else begin
            if (REMOTE_ONOFF_PIN_IN)
                low_cnt <= 12'h000;
            else if (low_cnt != 12'hfff)
                low_cnt <= low_cnt + 12'h001;
            if (boot_cnt != 19'h7ffff)
                boot_cnt <= boot_cnt + 19'h00001;
        end
    end

    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);

    a_cmd_answered:
    assert property ((CMD_WR_IN || CMD_RD_IN) |=> CMD_ACK_OUT != CMD_ERR_OUT)
        else $error("command not answered");
    a_no_stray_ack:
    assert property (!(CMD_WR_IN || CMD_RD_IN) |=> !CMD_ACK_OUT && !CMD_ERR_OUT)
        else $error("answer without command");
    a_err_reads_zero:
    assert property (CMD_RD_IN ##1 CMD_ERR_OUT |-> CMD_RDATA_OUT == 16'h0000)
        else $error("unknown code read not zero");
    a_boot_hold:
    assert property (boot_cnt < BOOT_CYCLES - 19'd1 |-> STATE_OUT == `COS_S_BOOT)
        else $error("boot period cut short");
    a_pin_debounce:
    assert property (STATE_OUT == `COS_S_ONDLY && $past(STATE_OUT) == `COS_S_OFF
        |-> low_cnt >= 12'd3000) else $error("pin acted on too early");
    a_on_via_delay:
    assert property ($rose(REG_EN_OUT) |-> $past(STATE_OUT) == `COS_S_ONDLY)
        else $error("ramp began without turn-on delay");
    a_off_idle:
    assert property (STATE_OUT == `COS_S_OFF |-> !REG_EN_OUT && !SINK_EN_OUT)
        else $error("output driven while off");
    a_vin_low_off:
    assert property ((VIN_MON_IN < VIN_OFF) [*4] |-> !REG_EN_OUT)
        else $error("running below input turn-off level");
    a_vin_high_off:
    assert property ((VIN_MON_IN > VIN_OV) [*4] |-> !REG_EN_OUT)
        else $error("running on input over-voltage");
    a_vout_ov_trip:
    assert property ((VOUT_MON_IN > VOUT_OV) [*4] |-> !REG_EN_OUT)
        else $error("output over-voltage not shut down");
    a_ot_trip:
    assert property ((TEMP_MON_IN > OT_FAULT) [*4] |-> !REG_EN_OUT)
        else $error("over-temperature not shut down");
endmodule // cos_seq_asserts

bind cos_sequencer cos_seq_asserts #(
    .BOOT_CYCLES(BOOT_CYCLES), .VIN_OFF(VIN_OFF), .VIN_OV(VIN_OV),
    .VOUT_OV(VOUT_OV), .OT_FAULT(OT_FAULT)
) cos_seq_asserts_i (
    .CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN),
    .CMD_WR_IN(CMD_WR_IN), .CMD_RD_IN(CMD_RD_IN),
    .CMD_RDATA_OUT(CMD_RDATA_OUT), .CMD_ACK_OUT(CMD_ACK_OUT),
    .CMD_ERR_OUT(CMD_ERR_OUT), .REMOTE_ONOFF_PIN_IN(REMOTE_ONOFF_PIN_IN),
    .VIN_MON_IN(VIN_MON_IN), .VOUT_MON_IN(VOUT_MON_IN),
    .TEMP_MON_IN(TEMP_MON_IN), .REG_EN_OUT(REG_EN_OUT),
    .SINK_EN_OUT(SINK_EN_OUT), .STATE_OUT(STATE_OUT)
);

/* File: testbench/cos_host.sv */
module cos_host (
    // Clock
    input wire logic clk_in,
    // Command strobes
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] code_out,
    output logic [15:0] wdata_out,
    // Remote switch, open floats high on the pull-up
    output logic pin_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        code_out = 8'h00;
        wdata_out = 16'h0000;
        pin_out = 1'b1;
    end

    // One-cycle strobe per command, as the port expects
    task automatic xfer(input logic wr, input logic [7:0] c,
                        input logic [15:0] d);
        @(negedge clk_in);
        wr_out = wr;
        rd_out = !wr;
        code_out = c;
        wdata_out = d;
        @(negedge clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        // Released bus must not keep showing the old word
        code_out = ~c;
        wdata_out = ~d;
    endtask

    task automatic hold(input logic v, input int cyc);
        @(negedge clk_in);
        pin_out = v;
        repeat (cyc) @(negedge clk_in);
    endtask
endmodule // cos_host

/* File: testbench/test_converter_onoff_sequencer.sv */
`include "cos_defs.vh"

module test_converter_onoff_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 60000;
    logic clk = 1'b0;
    logic resetn;
    logic wr, rd, ack, err, pin, reg_en, sink_en;
    logic [7:0] code;
    logic [15:0] wdata, rdata, vin, vout, temp, vref;
    logic [1:0] margin;
    logic [2:0] state;
    logic [4:0] fault;
    logic [17:0] exp_q[$];
    logic [31:0] seed;
    int errors = 0;
    int tests_run = 0;
    int ticks = 0;
    int i;
    logic [7:0] codes [9] = '{8'h02, 8'h21, 8'h22, 8'h51, 8'h60, 8'h61,
                              8'h64, 8'h65, 8'h66};
    logic [15:0] rsts [9] = '{{8'h00, `COS_ONOFF_RST}, `COS_VOUT_RST,
        `COS_TRIM_RST, `COS_OT_WARN_RST, `COS_TON_DLY_RST, `COS_RISE_RST,
        `COS_TOFF_DLY_RST, `COS_FALL_RST, `COS_SINK_LIM_RST};
    logic [15:0] mt [5] = '{16'h3200, 16'h3200, 16'h3600, 16'h2100, 16'h3000};
    logic [15:0] mv [5] = '{16'h3700, 16'h2d00, 16'h3800, 16'h2000, 16'h3000};
    logic [1:0] mm [5] = '{2'b01, 2'b10, 2'b01, 2'b10, 2'b00};

    cos_sequencer #(.BOOT_CYCLES(19'd100)) cos_sequencer_i (
        .CLK_SYS_IN(clk), .RESETN_IN(resetn), .CMD_WR_IN(wr),
        .CMD_RD_IN(rd), .CMD_CODE_IN(code), .CMD_WDATA_IN(wdata),
        .CMD_RDATA_OUT(rdata), .CMD_ACK_OUT(ack), .CMD_ERR_OUT(err),
        .REMOTE_ONOFF_PIN_IN(pin), .MARGIN_IN(margin), .VIN_MON_IN(vin),
        .VOUT_MON_IN(vout), .TEMP_MON_IN(temp), .REG_EN_OUT(reg_en),
        .SINK_EN_OUT(sink_en), .VREF_OUT(vref), .STATE_OUT(state),
        .FAULT_OUT(fault)
    );

    cos_host cos_host_i (
        .clk_in(clk), .wr_out(wr), .rd_out(rd), .code_out(code),
        .wdata_out(wdata), .pin_out(pin)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic results;
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_rsp(input logic [17:0] e);
        chk_val({15'h0000, err}, {15'h0000, e[16]});
        chk_val({15'h0000, ack}, {15'h0000, ~e[16]});
        if (e[17])
            chk_val(rdata, e[15:0]);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_st(input logic [2:0] s, input int max);
        int n;
        n = 0;
        while (state !== s && n < max) begin
            @(negedge clk);
            n++;
        end
        chk_val({13'h0000, state}, {13'h0000, s});
    endtask

    task automatic wr_cmd(input logic [7:0] c, input logic [15:0] d);
        exp_q.push_back(18'h00000);
        cos_host_i.xfer(1'b1, c, d);
    endtask

    task automatic rd_cmd(input logic [7:0] c, input logic [16:0] e);
        exp_q.push_back({1'b1, e});
        cos_host_i.xfer(1'b0, c, 16'h0000);
    endtask

    // Vin under-voltage needs the turn-on level again to restart; over-voltage only needs Vin back under VIN_OV
    task automatic trip(input logic k, input logic [15:0] bad, good,
                        input logic [4:0] f);
        if (k) vin = bad;
        else vout = bad;
        cyc(4);
        chk_val({15'h0000, reg_en}, 16'h0000);
        chk_val({11'h000, fault}, {11'h000, f});
        if (k) vin = good;
        else vout = good;
        wait_st(`COS_S_REG, 100);
    endtask

    always @(negedge clk) begin
        if (ack === 1'b1 || err === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("unexpected at %0t: answer with no request", $time);
            end else
                chk_rsp(exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        ticks++;
        if (ticks == LIMIT) begin
            errors++;
            results();
        end
    end

    initial begin
        margin = 2'b00;
        vin = 16'h0780;
        vout = 16'h0100;
        temp = 16'h0030;
        resetn = 1'b0;
        seed = 32'h0a1327c8;
        cyc(3);
        resetn = 1'b1;
        for (i = 0; i < 9; i++)
            rd_cmd(codes[i], {1'b0, rsts[i]});
        rd_cmd(8'h33, 17'h10000);
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wr_cmd(`COS_CMD_SINK_LIM, seed[15:0]);
            rd_cmd(`COS_CMD_SINK_LIM, {1'b0, seed[15:0]});
            wr_cmd(`COS_CMD_ONOFF_CFG, seed[31:16]);
            rd_cmd(`COS_CMD_ONOFF_CFG, {9'h000, seed[23:16]});
        end
        wr_cmd(`COS_CMD_ONOFF_CFG, 16'h0000);
        wr_cmd(`COS_CMD_STATUS, 16'hffff);
        wr_cmd(`COS_CMD_TURN_ON_RISE_TIME, 16'h0000);
        wr_cmd(`COS_CMD_TON_DLY, 16'h0002);
        wr_cmd(`COS_CMD_TOFF_DLY, 16'h0005);
        wait_st(`COS_S_OFF, 200);
        vin = 16'h0900;
        cos_host_i.hold(1'b0, 1000);
        cos_host_i.hold(1'b1, 10);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_OFF});
        vin = 16'h0680;
        cos_host_i.hold(1'b0, 3100);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_OFF});
        vin = 16'h0780;
        cyc(5);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_OFF});
        vin = 16'h0900;
        wait_st(`COS_S_ONDLY, 10);
        cyc(30);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_ONDLY});
        wait_st(`COS_S_RISE, 15);
        wait_st(`COS_S_REG, 10);
        chk_val(vref, `COS_VOUT_RST);
        vin = 16'h0780;
        cyc(20);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_REG});
        rd_cmd(`COS_CMD_STATUS, 17'h00260);
        for (i = 0; i < 5; i++) begin
            wr_cmd(`COS_CMD_VOUT_TGT, mt[i]);
            margin = mm[i];
            cyc(5);
            chk_val(vref, mv[i]);
        end
        wr_cmd(`COS_CMD_OUTPUT_VOLTAGE_TRIM, 16'h0100);
        cyc(5);
        chk_val(vref, 16'h3100);
        wr_cmd(`COS_CMD_OUTPUT_VOLTAGE_TRIM, 16'h0000);
        trip(1'b0, 16'h4100, 16'h0100, 5'h10);
        trip(1'b1, 16'h0500, 16'h0900, 5'h08);
        trip(1'b1, 16'h1000, 16'h0900, 5'h04);
        temp = 16'h0080;
        cyc(4);
        chk_val({15'h0000, reg_en}, 16'h0000);
        chk_val({11'h000, fault}, 16'h0001);
        temp = 16'h0070;
        cyc(100);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_OFF});
        temp = 16'h0030;
        wait_st(`COS_S_REG, 100);
        temp = 16'h0005;
        cyc(20);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_REG});
        chk_val({11'h000, fault}, 16'h0002);
        temp = 16'h0030;
        cos_host_i.hold(1'b1, 0);
        wait_st(`COS_S_OFF, 3010);
        wr_cmd(`COS_CMD_ONOFF_CFG, 16'h0001);
        wr_cmd(`COS_CMD_TURN_OFF_FALL_TIME, 16'h0000);
        cos_host_i.hold(1'b0, 0);
        wait_st(`COS_S_REG, 3200);
        cos_host_i.hold(1'b1, 0);
        wait_st(`COS_S_OFFDLY, 3010);
        cyc(90);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_OFFDLY});
        wait_st(`COS_S_OFF, 20);
        chk_val(vref, 16'h0000);
        wr_cmd(`COS_CMD_ONOFF_CFG, 16'h0000);
        vout = 16'h3400;
        wr_cmd(`COS_CMD_SINK_LIM, 16'h0001);
        wr_cmd(`COS_CMD_TURN_ON_RISE_TIME, 16'h0064);
        cos_host_i.hold(1'b0, 0);
        wait_st(`COS_S_RISE, 3200);
        chk_val({15'h0000, sink_en}, 16'h0001);
        cyc(30);
        chk_val({15'h0000, sink_en}, 16'h0000);
        wait_st(`COS_S_REG, 4000);
        chk_val(vref, `COS_VOUT_RST);
        cos_host_i.hold(1'b1, 0);
        wait_st(`COS_S_OFF, 3010);
        vout = 16'h2f00;
        cos_host_i.hold(1'b0, 0);
        wait_st(`COS_S_RISE, 3200);
        chk_val({15'h0000, sink_en}, 16'h0000);
        wr_cmd(`COS_CMD_TURN_ON_RISE_TIME, 16'h0000);
        cyc(1700);
        chk_val({13'h0000, state}, {13'h0000, `COS_S_RISE});
        wait_st(`COS_S_REG, 600);
        chk_val({15'h0000, sink_en}, 16'h0001);
        cyc(5);
        chk_val(16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule // test_converter_onoff_sequencer
